// ===== include/ppc_pkg.sv
/*
  Package for the port pad control block: register offsets, reset values,
  field positions and the interrupt layout.
  Assumes an 8-bit register port with byte offsets as printed.
*/
package ppc_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_P0_INPUT_MASK = 8'h84;
  localparam logic [7:0] OFS_P0_INPUT_SELECT = 8'h85;
  localparam logic [7:0] OFS_P0_PULLUP_N = 8'hB9;
  localparam logic [7:0] OFS_P1_PULLUP_N = 8'hBA;
  localparam logic [7:0] OFS_P3_PULLUP_N = 8'hBC;
  localparam logic [7:0] OFS_P0_OE_N = 8'hC0;
  localparam logic [7:0] OFS_P1_OE_N = 8'hC1;
  localparam logic [7:0] OFS_P3_OE_N = 8'hC2;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hC4;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hC5;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_P0_INPUT_MASK = 8'hFF;
  localparam logic [7:0] RST_P0_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_P0_PULLUP_N = 8'hFF;
  localparam logic [7:0] RST_P1_PULLUP_N = 8'h7F;
  localparam logic [7:0] RST_P3_PULLUP_N = 8'hFF;
  localparam logic [7:0] RST_OE_N = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;

  // ----------------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------------
  localparam int SEL_COMBINE_BIT = 0;
  localparam int SEL_WAKE_SRC_BIT = 1;
  localparam logic [7:0] SEL_WRITE_MASK = 8'h03;
  localparam logic [7:0] P1_CTRL_MASK = 8'h7F;
  localparam int P1_OUT_PIN = 7;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_COMBINE_FALL_BIT = 1;
  localparam logic [7:0] IRQ_USED_MASK = 8'h03;

endpackage : ppc_pkg

// ===== include/ppc_wake_if.sv
/*
  Interface between the pad control top and its wake-up selector.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
interface ppc_wake_if;
  logic wake_source_select;
  logic external_irq_line_a;
  logic external_irq_line_b;
  logic sleep_timer_wakeup;
  logic wake_request;

  modport ctrl (
    output wake_source_select,
    output external_irq_line_a,
    output external_irq_line_b,
    output sleep_timer_wakeup,
    input wake_request
  );

  modport sel (
    input wake_source_select,
    input external_irq_line_a,
    input external_irq_line_b,
    input sleep_timer_wakeup,
    output wake_request
  );
endinterface : ppc_wake_if

// ===== rtl/ppc_wake_sel.sv
/*
  Wake-up source selector for power-down exit.
  Assumes inputs synchronous to sys_clk; output is registered.
*/
`timescale 1ns/1ns
module ppc_wake_sel (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // selector link
  ppc_wake_if.sel wk
);
  import ppc_pkg::*;

  logic next_wake;

  // ----------------------------------------------------------------------
  // source choice
  // ----------------------------------------------------------------------
  always_comb begin
    if (wk.wake_source_select) begin
      next_wake = wk.sleep_timer_wakeup;
    end else begin
      // level wake on either line
      next_wake = wk.external_irq_line_a | wk.external_irq_line_b;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wk.wake_request <= 1'b0;
    end else begin
      wk.wake_request <= next_wake;
    end
  end

endmodule : ppc_wake_sel

// ===== rtl/ppc_pad_ctrl.sv
/*
  Pad control for ports 0, 1 and 3: output enables, pull-up enables, the
  port-0 masked combine onto port-1 pin 7, wake-up source choice and a
  small interrupt status/mask pair.
  Assumes a single-cycle register port, pins synchronous to sys_clk and
  port data values supplied by the port data registers outside.
*/
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns

module ppc_pad_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // port data values from the port data registers
  input wire logic [7:0] port0_data,
  input wire logic [7:0] port1_data,
  input wire logic [7:0] port3_data,
  // pad inputs
  input wire logic [7:0] port0_in,
  // pad drive
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  output logic [7:0] port3_out,
  output logic [7:0] port3_oe,
  // pull-up controls, high while pull-up is on
  output logic [7:0] port0_pullup_on,
  output logic [7:0] port1_pullup_on,
  output logic [7:0] port3_pullup_on,
  // wake-up
  input wire logic external_irq_line_a,
  input wire logic external_irq_line_b,
  input wire logic sleep_timer_wakeup,
  output logic wake_request,
  // interrupt
  output logic irq
);
  import ppc_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] port0_input_mask;
  logic [7:0] port0_input_select;
  logic [7:0] port0_pullup_enable_n;
  logic [7:0] port1_pullup_enable_n;
  logic [7:0] port3_pullup_enable_n;
  logic [7:0] port0_output_enable_n;
  logic [7:0] port1_output_enable_n;
  logic [7:0] port3_output_enable_n;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic masked_combine_select;
  logic wake_source_select;
  logic combined_output_pin;
  logic combine_prev;
  logic wake_prev;
  logic [7:0] next_rdata;
  logic [7:0] irq_events;
  logic [7:0] next_irq_status;
  logic status_read;

  assign masked_combine_select = port0_input_select[SEL_COMBINE_BIT];
  assign wake_source_select = port0_input_select[SEL_WAKE_SRC_BIT];

  // ----------------------------------------------------------------------
  // register writes, one flop group per register
  // ----------------------------------------------------------------------
  logic wr_p0_mask;
  logic wr_p0_select;
  logic wr_p0_pullup;
  logic wr_p1_pullup;
  logic wr_p3_pullup;
  logic wr_p0_oe;
  logic wr_p1_oe;
  logic wr_p3_oe;
  logic wr_irq_mask;

  assign wr_p0_mask = reg_write && (reg_addr == OFS_P0_INPUT_MASK);
  assign wr_p0_select = reg_write && (reg_addr == OFS_P0_INPUT_SELECT);
  assign wr_p0_pullup = reg_write && (reg_addr == OFS_P0_PULLUP_N);
  assign wr_p1_pullup = reg_write && (reg_addr == OFS_P1_PULLUP_N);
  assign wr_p3_pullup = reg_write && (reg_addr == OFS_P3_PULLUP_N);
  assign wr_p0_oe = reg_write && (reg_addr == OFS_P0_OE_N);
  assign wr_p1_oe = reg_write && (reg_addr == OFS_P1_OE_N);
  assign wr_p3_oe = reg_write && (reg_addr == OFS_P3_OE_N);
  assign wr_irq_mask = reg_write && (reg_addr == OFS_IRQ_MASK);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_input_mask <= RST_P0_INPUT_MASK;
    end else if (wr_p0_mask) begin
      port0_input_mask <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_input_select <= RST_P0_INPUT_SELECT;
    end else if (wr_p0_select) begin
      port0_input_select <= reg_wdata & SEL_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_pullup_enable_n <= RST_P0_PULLUP_N;
    end else if (wr_p0_pullup) begin
      port0_pullup_enable_n <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_pullup_enable_n <= RST_P1_PULLUP_N;
    end else if (wr_p1_pullup) begin
      port1_pullup_enable_n <= reg_wdata & P1_CTRL_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_pullup_enable_n <= RST_P3_PULLUP_N;
    end else if (wr_p3_pullup) begin
      port3_pullup_enable_n <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_output_enable_n <= RST_OE_N;
    end else if (wr_p0_oe) begin
      port0_output_enable_n <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_output_enable_n <= RST_OE_N;
    end else if (wr_p1_oe) begin
      port1_output_enable_n <= reg_wdata & P1_CTRL_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_output_enable_n <= RST_OE_N;
    end else if (wr_p3_oe) begin
      port3_output_enable_n <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= RST_IRQ;
    end else if (wr_irq_mask) begin
      irq_mask <= reg_wdata & IRQ_USED_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      OFS_P0_INPUT_MASK: next_rdata = port0_input_mask;
      OFS_P0_INPUT_SELECT: next_rdata = port0_input_select;
      OFS_P0_PULLUP_N: next_rdata = port0_pullup_enable_n;
      OFS_P1_PULLUP_N: next_rdata = port1_pullup_enable_n;
      OFS_P3_PULLUP_N: next_rdata = port3_pullup_enable_n;
      OFS_P0_OE_N: next_rdata = port0_output_enable_n;
      OFS_P1_OE_N: next_rdata = port1_output_enable_n;
      OFS_P3_OE_N: next_rdata = port3_output_enable_n;
      OFS_IRQ_STATUS: next_rdata = irq_status;
      OFS_IRQ_MASK: next_rdata = irq_mask;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // masked combine of port 0
  // ----------------------------------------------------------------------
  wire logic [7:0] combine_terms;

  for (genvar i = 0; i < 8; i++) begin : g_combine
    assign combine_terms[i] = port0_in[i] | port0_input_mask[i];
  end

  assign combined_output_pin = &combine_terms;

  // ----------------------------------------------------------------------
  // pad drive, enables active high towards the pad
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_out <= 8'h00;
      port0_oe <= 8'h00;
    end else begin
      port0_out <= port0_data;
      port0_oe <= ~port0_output_enable_n;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_out <= 8'h00;
      port3_oe <= 8'h00;
    end else begin
      port3_out <= port3_data;
      port3_oe <= ~port3_output_enable_n;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_out <= 8'h00;
      port1_oe <= 8'h00;
    end else begin
      port1_out[P1_OUT_PIN-1:0] <= port1_data[P1_OUT_PIN-1:0];
      port1_oe[P1_OUT_PIN-1:0] <= ~port1_output_enable_n[P1_OUT_PIN-1:0];
      port1_oe[P1_OUT_PIN] <= 1'b1;
      if (masked_combine_select) begin
        port1_out[P1_OUT_PIN] <= combined_output_pin;
      end else begin
        port1_out[P1_OUT_PIN] <= port1_data[P1_OUT_PIN];
      end
    end
  end

  // ----------------------------------------------------------------------
  // pull-up controls
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_pullup_on <= 8'h00;
    end else begin
      port0_pullup_on <= ~port0_pullup_enable_n;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_pullup_on <= 8'h00;
    end else begin
      port1_pullup_on <= ~port1_pullup_enable_n & P1_CTRL_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_pullup_on <= 8'h00;
    end else begin
      port3_pullup_on <= ~port3_pullup_enable_n;
    end
  end

  // ----------------------------------------------------------------------
  // wake-up selector
  // ----------------------------------------------------------------------
  ppc_wake_if wk_if ();

  assign wk_if.wake_source_select = wake_source_select;
  assign wk_if.external_irq_line_a = external_irq_line_a;
  assign wk_if.external_irq_line_b = external_irq_line_b;
  assign wk_if.sleep_timer_wakeup = sleep_timer_wakeup;
  assign wake_request = wk_if.wake_request;

  ppc_wake_sel u_wake_sel (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wk(wk_if.sel)
  );

  // ----------------------------------------------------------------------
  // interrupt status: rising wake, falling combine result
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      combine_prev <= 1'b1;
      wake_prev <= 1'b0;
    end else begin
      combine_prev <= combined_output_pin;
      wake_prev <= wake_request;
    end
  end

  assign status_read = reg_read && (reg_addr == OFS_IRQ_STATUS);

  always_comb begin
    irq_events = 8'h00;
    irq_events[IRQ_WAKE_BIT] = wake_request & ~wake_prev;
    irq_events[IRQ_COMBINE_FALL_BIT] = masked_combine_select &
                                       combine_prev & ~combined_output_pin;
    // a new event beats the clear-on-read
    if (status_read) begin
      next_irq_status = irq_events;
    end else begin
      next_irq_status = irq_status | irq_events;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule : ppc_pad_ctrl

// ===== testbench/ppc_pad_ctrl_monitor.sv
/* Checker for ppc_pad_ctrl, shadowing registers from bus writes.
   Assumes the bind in the testbench top. */
`timescale 1ns/1ns
module ppc_pad_ctrl_monitor
  import ppc_pkg::*;
(
  // clock, reset, register port
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // pads and wake
  input wire logic [7:0] port0_data,
  input wire logic [7:0] port1_data,
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port0_oe,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  input wire logic [7:0] port0_pullup_on,
  input wire logic [7:0] port1_pullup_on,
  input wire logic external_irq_line_a,
  input wire logic external_irq_line_b,
  input wire logic sleep_timer_wakeup,
  input wire logic wake_request
);
  logic [7:0] msk;
  logic [7:0] sel;
  logic [7:0] pu0;
  logic [7:0] oe0;
  wire comb_now = &(port0_in | msk);
  wire ext_any = external_irq_line_a | external_irq_line_b;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      msk <= RST_P0_INPUT_MASK;
      sel <= RST_P0_INPUT_SELECT;
      pu0 <= RST_P0_PULLUP_N;
      oe0 <= RST_OE_N;
    end else if (reg_write) begin
      if (reg_addr == OFS_P0_INPUT_MASK) msk <= reg_wdata;
      if (reg_addr == OFS_P0_INPUT_SELECT) sel <= reg_wdata & SEL_WRITE_MASK;
      if (reg_addr == OFS_P0_PULLUP_N) pu0 <= reg_wdata;
      if (reg_addr == OFS_P0_OE_N) oe0 <= reg_wdata;
    end
  end
  a_p1_pin7_out: assert property ($past(rst_n) |-> port1_oe[7])
    else $error("pin 7 of port 1 not driven");
  a_p1_pu7_off: assert property (##1 !port1_pullup_on[7])
    else $error("pin 7 of port 1 has a pull-up");
  a_out_follow: assert property ($past(rst_n) |-> port0_out ==
    $past(port0_data) && port1_out[6:0] == $past(port1_data[6:0]))
    else $error("pad output not following data");
  a_oe_reg: assert property ($past(rst_n) |-> port0_oe == ~$past(oe0))
    else $error("port 0 drive enable wrong");
  a_pullup_reg: assert property ($past(rst_n) |->
    port0_pullup_on == ~$past(pu0)) else $error("port 0 pull-up wrong");
  a_combine_on: assert property ($past(rst_n) && $past(sel[0]) |->
    port1_out[7] == $past(comb_now)) else $error("combined output wrong");
  a_combine_off: assert property ($past(rst_n) && !$past(sel[0]) |->
    port1_out[7] == $past(port1_data[7])) else $error("pin 7 not data");
  a_wake_lines: assert property ($past(rst_n) && !$past(sel[1]) |->
    wake_request == $past(ext_any)) else $error("line wake wrong");
  a_wake_timer: assert property ($past(rst_n) && $past(sel[1]) |->
    wake_request == $past(sleep_timer_wakeup)) else $error("timer wake wrong");
  a_mask_read: assert property (reg_read && reg_addr == OFS_P0_INPUT_MASK
    |=> reg_rdata == $past(msk)) else $error("mask read wrong");
  c_combine_fall: cover property (sel[0] && $fell(port1_out[7]));
  c_wake_rise: cover property ($rose(wake_request));
  c_p0_input: cover property (port0_oe == 8'h00 && pu0 == 8'h00);
endmodule : ppc_pad_ctrl_monitor

// ===== testbench/ppc_pad_board.sv
/* Board model for port 0: each pad from driver, outside source, pull-up.
   Assumes pads sensed on sys_clk. */
`timescale 1ns/1ns
module ppc_pad_board (
  // design side
  input wire logic sys_clk,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port0_oe,
  input wire logic [7:0] port0_pullup_on,
  // outside source and sensed level
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_on,
  output logic [7:0] port0_in
);
  logic [7:0] last;
  always_ff @(posedge sys_clk) last <= port0_in;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (port0_oe[i]) port0_in[i] = port0_out[i];
      else if (ext_on[i]) port0_in[i] = ext_val[i];
      else if (port0_pullup_on[i]) port0_in[i] = 1'b1;
      else port0_in[i] = ~last[i];
    end
  end
endmodule : ppc_pad_board

// ===== testbench/tb_ppc_pad_ctrl.sv
/* Top testbench for ppc_pad_ctrl with the port-0 board model.
   Assumes package, monitor and board model compiled first. */
`timescale 1ns/1ns
module tb_ppc_pad_ctrl;
  import ppc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_write = 1'b0, reg_read = 1'b0, rd_seen = 1'b0;
  logic [7:0] port0_data = 8'h00, port1_data = 8'h00, port3_data = 8'h00;
  logic [7:0] port0_in, port0_out, port0_oe, port1_out, port1_oe;
  logic [7:0] port3_out, port3_oe, port0_pullup_on, port1_pullup_on;
  logic [7:0] port3_pullup_on, ext_val = 8'h00, ext_on = 8'hFF;
  logic external_irq_line_a = 1'b0, external_irq_line_b = 1'b0;
  logic sleep_timer_wakeup = 1'b0, wake_request, irq;
  logic [7:0] m, v, on, exp_q[$];
  logic [7:0] ra[10] = '{OFS_P0_INPUT_MASK, OFS_P0_INPUT_SELECT,
    OFS_P0_PULLUP_N, OFS_P1_PULLUP_N, OFS_P3_PULLUP_N, OFS_P0_OE_N,
    OFS_P1_OE_N, OFS_P3_OE_N, OFS_IRQ_MASK, 8'h10};
  logic [7:0] rv[10] = '{RST_P0_INPUT_MASK, RST_P0_INPUT_SELECT,
    RST_P0_PULLUP_N, RST_P1_PULLUP_N, RST_P3_PULLUP_N, RST_OE_N,
    RST_OE_N, RST_OE_N, RST_IRQ, 8'h00};
  int n_errors = 0, checked = 0, cycles = 0;
  always #25 sys_clk = ~sys_clk;
  ppc_pad_ctrl dut_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .port0_data, .port1_data, .port3_data, .port0_in,
    .port0_out, .port0_oe, .port1_out, .port1_oe, .port3_out, .port3_oe,
    .port0_pullup_on, .port1_pullup_on, .port3_pullup_on, .external_irq_line_a,
    .external_irq_line_b, .sleep_timer_wakeup, .wake_request, .irq);
  ppc_pad_board board_u (.sys_clk, .port0_out, .port0_oe, .port0_pullup_on,
    .ext_val, .ext_on, .port0_in);
  task automatic test_done;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle
  // read data checked against the oldest note
  always @(posedge sys_clk) begin
    if (rd_seen) chk(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_read;
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'hB07C7566));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    settle;
    chk(port0_oe & port1_oe & port3_oe, 8'hFF);
    chk(port0_pullup_on | port1_pullup_on | port3_pullup_on, 8'h00);
    $display("test reset done");
    wr(OFS_P0_INPUT_SELECT, 8'hFC);
    rd(OFS_P0_INPUT_SELECT, 8'h00);
    wr(OFS_P1_OE_N, 8'hFF);
    rd(OFS_P1_OE_N, 8'h7F);
    wr(OFS_P1_PULLUP_N, 8'h80);
    rd(OFS_P1_PULLUP_N, 8'h00);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    settle;
    chk(port1_oe, 8'h80);
    chk(port1_pullup_on, 8'h7F);
    $display("test fields done");
    wr(OFS_IRQ_MASK, 8'h01);
    rd(OFS_IRQ_MASK, 8'h01);
    external_irq_line_a <= 1'b1;
    settle;
    settle;
    chk({7'h00, irq}, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h01);
    settle;
    chk({7'h00, irq}, 8'h00);
    wr(OFS_IRQ_MASK, 8'h00);
    external_irq_line_a <= 1'b0;
    settle;
    @(posedge sys_clk);
    external_irq_line_a <= 1'b1;
    settle;
    settle;
    chk({7'h00, irq}, 8'h00);
    rd(OFS_IRQ_STATUS, 8'h01);
    $display("test interrupt done");
    wr(OFS_P0_OE_N, 8'hFF);
    wr(OFS_P0_PULLUP_N, 8'h00);
    wr(OFS_P0_INPUT_SELECT, 8'h01);
    repeat (16) begin
      m = $urandom;
      v = $urandom;
      on = $urandom;
      wr(OFS_P0_INPUT_MASK, m);
      rd(OFS_P0_INPUT_MASK, m);
      ext_val <= v;
      ext_on <= on;
      port0_data <= $urandom;
      port3_data <= $urandom;
      settle;
      chk({7'h00, port1_out[7]}, {7'h00, &(v | ~on | m)});
      chk(port0_oe, 8'h00);
    end
    wr(OFS_P0_INPUT_SELECT, 8'h00);
    port1_data <= $urandom;
    settle;
    chk(port1_out, port1_data);
    chk(port3_out, port3_data);
    $display("test combine done");
    for (int s = 0; s < 2; s++) begin
      wr(OFS_P0_INPUT_SELECT, s ? 8'h02 : 8'h00);
      for (int k = 0; k < 8; k++) begin
        @(posedge sys_clk);
        {sleep_timer_wakeup, external_irq_line_b,
         external_irq_line_a} <= k[2:0];
        settle;
        chk({7'h00, wake_request}, {7'h00, s ? k[2] : |k[1:0]});
      end
    end
    $display("test wake done");
    settle;
    test_done();
  end
endmodule : tb_ppc_pad_ctrl
bind ppc_pad_ctrl ppc_pad_ctrl_monitor mon_u (.sys_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .port0_data, .port1_data,
  .port0_in, .port0_out, .port0_oe, .port1_out, .port1_oe, .port0_pullup_on,
  .port1_pullup_on, .external_irq_line_a, .external_irq_line_b,
  .sleep_timer_wakeup, .wake_request);
